// ===== rtl/sic_pkg.sv
// Purpose: Shared constants and types for the scanner input conditioning block.
// Assumes: System clock of 250 MHz.
// Notes: Debounce counts are derived from the printed delays.
`default_nettype none
package sic_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned DEB_LONG_US = 5000;
  localparam int unsigned DEB_SHORT_US = 500;
  localparam int unsigned DEB_LONG_CYC = (CLK_HZ / 1000000) * DEB_LONG_US;
  localparam int unsigned DEB_SHORT_CYC = (CLK_HZ / 1000000) * DEB_SHORT_US;
  localparam int CNT_W = 21;
  localparam int NUM_IN = 4;
  localparam int IDX_TRIG = 0;
  localparam int IDX_ENC = 1;
  localparam int IDX_GEN_A = 2;
  localparam int IDX_GEN_B = 3;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [31:0] SPEED_RST = 32'h0;
  // Operating modes relevant to the inputs.
  typedef enum logic [1:0]
  {
    SIC_MODE_FREE = 2'h0,
    SIC_MODE_TRIGGERED = 2'h1,
    SIC_MODE_TRACKING = 2'h2
  } sic_mode_t;
  // Verifier capture sequence, one-hot.
  typedef enum logic [2:0]
  {
    SIC_CAP_IDLE = 3'h1,
    SIC_CAP_ARMED = 3'h2,
    SIC_CAP_STORE = 3'h4
  } sic_cap_t;
endpackage
`default_nettype wire

// ===== rtl/sic_input_cond.sv
// Purpose: Conditions four isolated inputs and routes them to scanner functions.
// Assumes: Inputs are asynchronous to ref_clk; encoder stays below 1 kHz.
// Notes: Long debounce counts are top-level parameters so a simulation can shorten them.
`default_nettype none
module sic_input_cond
  import sic_pkg::*;
#(
  parameter int unsigned DEB_LONG = sic_pkg::DEB_LONG_CYC,
  parameter int unsigned DEB_SHORT = sic_pkg::DEB_SHORT_CYC,
  parameter int unsigned SPEED_WINDOW = sic_pkg::CLK_HZ
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic trigger_input,
  input wire logic encoder_input,
  input wire logic generic_input_a,
  input wire logic generic_input_b,
  input wire logic [3:0] active_closed,
  input wire logic shared_deb_long,
  input wire logic encoder_deb_long,
  input wire sic_pkg::sic_mode_t op_mode,
  input wire logic stop_enable,
  input wire logic stop_sel_b,
  input wire logic capture_enable,
  input wire logic capture_sel_b,
  input wire logic verifier_enable,
  input wire logic code_cfg_saved,
  input wire logic decode_good,
  output logic phase_led,
  output logic scan_start,
  output logic reading_stop,
  output logic encoder_pulse,
  output logic [31:0] encoder_speed,
  output logic verifier_store,
  output logic [3:0] input_active
);
  import sic_pkg::*;

  logic [3:0] raw;
  logic [3:0] s1_r, s2_r, s3_r;
  logic [3:0] level_r;
  logic [3:0] act_d_r;
  logic edge_ok_r;
  logic [CNT_W-1:0] cnt_r [NUM_IN];
  logic [31:0] win_cnt_r, pulse_cnt_r;
  sic_cap_t cap_r;

  assign raw = {generic_input_b, generic_input_a, encoder_input, trigger_input};

  // Three-stage synchronisers; only stages two and three are compared.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r <= LEVEL_RST;
      s2_r <= LEVEL_RST;
      s3_r <= LEVEL_RST;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per-input debounce: count while the settled sample differs from the accepted level.
  for (genvar i = 0; i < NUM_IN; i++)
  begin : g_deb
    logic use_long;
    logic [CNT_W-1:0] limit;
    assign use_long = (i == IDX_ENC) ? encoder_deb_long : shared_deb_long;
    assign limit = use_long ? CNT_W'(DEB_LONG - 1) : CNT_W'(DEB_SHORT - 1);
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        cnt_r[i] <= '0;
        level_r[i] <= 1'b0;
      end
      else if (s2_r[i] != s3_r[i] || s3_r[i] == level_r[i])
      begin
        cnt_r[i] <= '0;
      end
      else if (cnt_r[i] >= limit)
      begin
        cnt_r[i] <= '0;
        level_r[i] <= s3_r[i];
      end
      else
      begin
        cnt_r[i] <= cnt_r[i] + 1'b1;
      end
    end
  end

  // Logical active state: high level means current flows, i.e. circuit closed.
  logic [3:0] act;
  assign act = ~(level_r ^ active_closed);
  logic [3:0] rise;
  // Edges are masked in the first cycle after reset, so an active-open input (active_closed bit clear) that idles open
  // does not fire a false scan start, stop or capture.
  assign rise = act & ~act_d_r & {4{edge_ok_r}};

  // Registered logical states, edge history and direct indicator.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      act_d_r <= LEVEL_RST;
      edge_ok_r <= 1'b0;
      input_active <= LEVEL_RST;
      phase_led <= 1'b0;
    end
    else
    begin
      act_d_r <= act;
      edge_ok_r <= 1'b1;
      input_active <= act;
      phase_led <= s3_r[IDX_TRIG];
    end
  end

  // Function routing: scan start, reading stop, encoder pulse.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scan_start <= 1'b0;
      reading_stop <= 1'b0;
      encoder_pulse <= 1'b0;
    end
    else
    begin
      scan_start <= rise[IDX_TRIG] && (op_mode == SIC_MODE_TRIGGERED
                                       || op_mode == SIC_MODE_TRACKING);
      reading_stop <= stop_enable && (stop_sel_b ? rise[IDX_GEN_B] : rise[IDX_GEN_A]);
      encoder_pulse <= rise[IDX_ENC] && op_mode == SIC_MODE_TRACKING;
    end
  end

  // Speed: encoder pulses counted over a fixed window of clock cycles.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      win_cnt_r <= '0;
      pulse_cnt_r <= '0;
      encoder_speed <= SPEED_RST;
    end
    else if (op_mode != SIC_MODE_TRACKING)
    begin
      win_cnt_r <= '0;
      pulse_cnt_r <= '0;
    end
    else if (win_cnt_r >= SPEED_WINDOW - 1)
    begin
      win_cnt_r <= '0;
      pulse_cnt_r <= 32'(rise[IDX_ENC]);
      encoder_speed <= pulse_cnt_r;
    end
    else
    begin
      win_cnt_r <= win_cnt_r + 32'h1;
      pulse_cnt_r <= pulse_cnt_r + 32'(rise[IDX_ENC]);
    end
  end

  // Verifier capture: arm on the capture input, store on the next good decode.
  logic cap_ok, cap_rise;
  assign cap_ok = capture_enable && verifier_enable && code_cfg_saved;
  assign cap_rise = capture_sel_b ? rise[IDX_GEN_B] : rise[IDX_GEN_A];
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_r <= SIC_CAP_IDLE;
      verifier_store <= 1'b0;
    end
    else
    begin
      verifier_store <= 1'b0;
      unique case (cap_r)
        SIC_CAP_IDLE:
        begin
          if (cap_ok && cap_rise)
          begin
            cap_r <= SIC_CAP_ARMED;
          end
        end
        SIC_CAP_ARMED:
        begin
          if (!cap_ok)
          begin
            cap_r <= SIC_CAP_IDLE;
          end
          else if (decode_good)
          begin
            cap_r <= SIC_CAP_STORE;
            verifier_store <= 1'b1;
          end
        end
        SIC_CAP_STORE:
        begin
          cap_r <= SIC_CAP_IDLE;
        end
        default:
        begin
          cap_r <= SIC_CAP_IDLE;
        end
      endcase
    end
  end

  // Checks on the routed functions, the encoder debounce and the active state polarity.
  property p_scan_mode;
    @(posedge ref_clk) disable iff (!resetn)
    scan_start |-> $past(op_mode) == SIC_MODE_TRIGGERED || $past(op_mode) == SIC_MODE_TRACKING;
  endproperty
  a_scan_mode: assert property (p_scan_mode) else $error("scan start outside trigger modes");

  property p_led_raw;
    @(posedge ref_clk) disable iff (!resetn)
    ##1 phase_led == $past(s3_r[IDX_TRIG]);
  endproperty
  a_led_raw: assert property (p_led_raw) else $error("phase led not following raw input");

  property p_store_gated;
    @(posedge ref_clk) disable iff (!resetn)
    verifier_store |-> $past(cap_ok) && $past(decode_good);
  endproperty
  a_store_gated: assert property (p_store_gated) else $error("store without enable");

  sequence s_armed;
    cap_r == SIC_CAP_ARMED && cap_ok && decode_good;
  endsequence
  property p_store_next;
    @(posedge ref_clk) disable iff (!resetn)
    s_armed |=> verifier_store ##1 cap_r == SIC_CAP_IDLE;
  endproperty
  a_store_next: assert property (p_store_next) else $error("capture not stored");

  property p_deb_hold;
    @(posedge ref_clk) disable iff (!resetn)
    $changed(level_r[IDX_ENC]) |-> $past(s3_r[IDX_ENC]) == level_r[IDX_ENC];
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("encoder level took unstable value");

  property p_stop_src;
    @(posedge ref_clk) disable iff (!resetn)
    reading_stop |-> $past(stop_enable) && $past(rise[IDX_GEN_A] | rise[IDX_GEN_B]);
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("stop without generic input");

  property p_enc_mode;
    @(posedge ref_clk) disable iff (!resetn)
    encoder_pulse |-> $past(op_mode) == SIC_MODE_TRACKING;
  endproperty
  a_enc_mode: assert property (p_enc_mode) else $error("encoder pulse outside tracking");

  property p_polarity;
    @(posedge ref_clk) disable iff (!resetn)
    $past(resetn) |-> input_active == $past(~(level_r ^ active_closed));
  endproperty
  a_polarity: assert property (p_polarity) else $error("active state polarity wrong");
endmodule
`default_nettype wire

// ===== verif/sic_sensor_model.sv
// Purpose: Photocell, encoder and switch contacts on the four pins.
// Assumes: The bench changes want just after a ref_clk edge.
// Notes: Each change chatters for a few cycles, well under any delay.
`default_nettype none
module sic_sensor_model (
  input wire logic ref_clk,
  input wire logic [3:0] want,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] prev_r = 4'h0;
  int bnc [4] = '{0, 0, 0, 0};
  initial pins = 4'h0;
  // Contact bounce follows every change of the commanded level.
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (want[i] !== prev_r[i])
        bnc[i] <= 3;
      else if (bnc[i] > 0)
        bnc[i] <= bnc[i] - 1;
      pins[i] <= (bnc[i] > 0 && bnc[i][0]) ? ~want[i] : want[i];
    end
    prev_r <= want;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the input conditioning block.
// Assumes: Short debounce and speed window parameters.
// Notes: Outputs are sampled on the falling edge.
`default_nettype none
module tb;
  import sic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DL = 20;
  localparam int DS = 8;
  localparam int W = 100;
  logic ref_clk = 1'b0, resetn = 1'b0, shared_deb_long = 1'b0, encoder_deb_long = 1'b0;
  logic stop_enable = 1'b0, stop_sel_b = 1'b0, capture_enable = 1'b0, capture_sel_b = 1'b0;
  logic verifier_enable = 1'b0, code_cfg_saved = 1'b0, decode_good = 1'b0;
  logic [3:0] want = 4'h0, active_closed = 4'h0, pins, input_active;
  sic_mode_t op_mode = SIC_MODE_TRIGGERED;
  logic phase_led, scan_start, reading_stop, encoder_pulse, verifier_store;
  logic [31:0] encoder_speed, sum, rng = 32'h63;
  int fail_count = 0, cmp_count = 0, n_sc = 0, n_rs = 0, n_ep = 0, n_vs = 0, k, g;
  sic_sensor_model sens (.ref_clk, .want, .pins);
  sic_input_cond #(.DEB_LONG(DL), .DEB_SHORT(DS), .SPEED_WINDOW(W)) dut (.ref_clk, .resetn,
    .trigger_input(pins[0]), .encoder_input(pins[1]), .generic_input_a(pins[2]),
    .generic_input_b(pins[3]), .active_closed, .shared_deb_long, .encoder_deb_long,
    .op_mode, .stop_enable, .stop_sel_b, .capture_enable, .capture_sel_b, .verifier_enable,
    .code_cfg_saved, .decode_good, .phase_led, .scan_start, .reading_stop, .encoder_pulse,
    .encoder_speed, .verifier_store, .input_active);
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Debounce length expected for one input from its delay select.
  function automatic int dly(input int i);
    return ((i == 1) ? encoder_deb_long : shared_deb_long) ? DL : DS;
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input string m);
    // Sync stages, register stages and contact bounce add six to twelve cycles.
    chk_val(32'(got >= lo + 6 && got <= lo + 12), 32'h1, m);
  endtask
  // Moves one pin and times the logical change against the delay.
  task automatic move(input int i, input logic lvl);
    int c;
    c = 0;
    @(posedge ref_clk);
    want[i] <= lvl;
    do
    begin
      @(negedge ref_clk);
      c++;
    end while (input_active[i] !== (lvl == active_closed[i]) && c < 300);
    chk_rng(c, dly(i), "debounce delay");
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2 ref_clk = ~ref_clk;
  // Counts output pulses.
  always @(negedge ref_clk)
  begin
    n_sc += int'(scan_start === 1'b1);
    n_rs += int'(reading_stop === 1'b1);
    n_ep += int'(encoder_pulse === 1'b1);
    n_vs += int'(verifier_store === 1'b1);
  end
  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_val(32'(input_active), 32'hf, "open active");
    chk_val(n_sc, 32'h0, "no start after reset");
    @(posedge ref_clk);
    active_closed <= 4'he;
    repeat (3) @(negedge ref_clk);
    chk_val({input_active, 3'h0, phase_led}, 32'h10, "closed active");
    move(0, 1'b1);
    chk_val({input_active[0], phase_led}, 32'h1, "led raw");
    move(0, 1'b0);
    @(posedge ref_clk);
    active_closed <= 4'hf;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge ref_clk);
      op_mode <= sic_mode_t'(m);
      shared_deb_long <= 1'(xs());
      n_sc = 0;
      move(0, 1'b1);
      move(0, 1'b0);
      chk_val(n_sc, 32'(m == 1 || m == 2), "scan start");
    end
    // Encoder delay differs from the shared one so a swapped select shows up.
    @(posedge ref_clk);
    op_mode <= SIC_MODE_TRACKING;
    encoder_deb_long <= ~shared_deb_long;
    k = int'(xs() % 3) + 1;
    n_ep = 0;
    sum = 32'h0;
    fork
      repeat (k)
      begin
        move(1, 1'b1);
        move(1, 1'b0);
        repeat (10) @(posedge ref_clk);
      end
      repeat (5)
      begin
        repeat (W) @(negedge ref_clk);
        sum += encoder_speed;
      end
    join
    chk_val(n_ep, k, "encoder pulses");
    chk_val(sum, k, "encoder speed");
    for (int s = 0; s < 3; s++)
    begin
      @(posedge ref_clk);
      stop_enable <= (s != 2);
      stop_sel_b <= 1'(s);
      n_rs = 0;
      move(2, 1'b1);
      move(3, 1'b1);
      move(2, 1'b0);
      move(3, 1'b0);
      chk_val(n_rs, 32'(s != 2), "stop");
    end
    @(posedge ref_clk);
    stop_enable <= 1'b1;
    stop_sel_b <= 1'b0;
    shared_deb_long <= 1'b0;
    want[2] <= 1'b1;
    n_rs = 0;
    repeat (2) @(posedge ref_clk);
    want[2] <= 1'b0;
    repeat (40) @(negedge ref_clk);
    chk_val({n_rs[30:0], input_active[2]}, 32'h0, "glitch");
    for (int v = 0; v < 4; v++)
    begin
      g = 2 + int'(xs() % 2);
      @(posedge ref_clk);
      capture_enable <= 1'b1;
      capture_sel_b <= (g == 3);
      verifier_enable <= v[0];
      code_cfg_saved <= v[1];
      n_vs = 0;
      move(g, 1'b1);
      repeat (2)
      begin
        @(posedge ref_clk);
        decode_good <= 1'b1;
        @(posedge ref_clk);
        decode_good <= 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      chk_val(n_vs, 32'(v == 3), "capture");
      move(g, 1'b0);
    end
    // Armed capture that loses its enable must not store a later decode.
    @(posedge ref_clk);
    capture_sel_b <= 1'b0;
    verifier_enable <= 1'b1;
    code_cfg_saved <= 1'b1;
    n_vs = 0;
    move(2, 1'b1);
    @(posedge ref_clk);
    verifier_enable <= 1'b0;
    @(posedge ref_clk);
    verifier_enable <= 1'b1;
    decode_good <= 1'b1;
    @(posedge ref_clk);
    decode_good <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_val(n_vs, 32'h0, "capture dropped");
    move(2, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
